// file: rtl/vrdac_regs.svh
`ifndef VRDAC_REGS_SVH
`define VRDAC_REGS_SVH

// Word byte addresses on the Wishbone slave
`define VRDAC_OFF_CONTROL0 4'h0
`define VRDAC_OFF_LEVEL 4'h4

// Field positions in control register 0
`define VRDAC_BIT_ENABLE 7
`define VRDAC_BIT_PIN_ONE 5
`define VRDAC_BIT_PIN_TWO 4
`define VRDAC_BIT_PSS 2

// Implemented bits of each register
`define VRDAC_CONTROL0_MASK 8'hB4
`define VRDAC_LEVEL_MASK 8'h1F

// Reset values
`define VRDAC_CONTROL0_RESET 8'h00
`define VRDAC_LEVEL_RESET 8'h00

`endif

// file: rtl/vrdac_pkg.sv
package vrdac_pkg;

	typedef enum logic {
		VRDAC_SRC_SUPPLY,
		VRDAC_SRC_EXT_PIN
	} vrdac_source_type;

	typedef struct packed {
		logic [7:0] control0;
		logic [7:0] level;
		logic ack;
	} vrdac_state_type;

endpackage

// file: rtl/vrdac_pin_override.sv
`timescale 1ns/1ps

module vrdac_pin_override (
	input wire logic connect,
	input wire logic port_out,
	input wire logic port_oe,
	input wire logic pullup_en,
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic pad_pullup,
	output logic pad_analog,
	output logic read_value
);

	// Analog output takes the pad away from the digital port
	always_comb begin
		pad_analog = connect;
		pad_out = connect ? 1'b0 : port_out;
		pad_oe = connect ? 1'b0 : port_oe;
		pad_pullup = connect ? 1'b0 : pullup_en;
		read_value = connect ? 1'b0 : pad_in;
	end

endmodule

// file: rtl/vrdac_control.sv
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "vrdac_regs.svh"

// Operation
// - Control0 is 8 bits: enable bit 7, pin connects 5 and 4, source select 2.
// - Level register holds the 5-bit level code in bits 4 to 0.
// - Source select 1 picks external reference pin, 0 picks supply rail.
// - Level code picks the output level; software reads and writes it.
// - Level register bits 7 to 5 ignore writes and read zero.
// - Control0 bits 6, 3, 1, 0 ignore writes and read zero.
// - All implemented bits of both registers reset to zero.
// - Converter active only while enable is set.
// - Pin connect drives converter onto pin, overrides digital, reads zero.
// - Output equals negative source plus difference times code over 32.
// - Reset disables converter, disconnects both pins, clears the level code.
module vrdac_control (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic converter_enable,
	output logic ladder_top_ext_pin,
	output logic [4:0] ladder_tap,
	output logic ladder_zero,
	input wire logic [1:0] port_out,
	input wire logic [1:0] port_oe,
	input wire logic [1:0] pullup_en,
	input wire logic [1:0] pad_in,
	output logic [1:0] pad_out,
	output logic [1:0] pad_oe,
	output logic [1:0] pad_pullup,
	output logic [1:0] pad_analog,
	output logic [1:0] pin_read
);

	vrdac_pkg::vrdac_state_type state_q, state_d;
	logic req;
	logic hit_c0;
	logic hit_lv;
	logic [1:0] pad_in_q1, pad_in_q2, pad_in_q3;
	logic [1:0] pad_in_sync;
	logic [1:0] connect;
	logic [31:0] rdata_q;
	vrdac_pkg::vrdac_source_type src;

	function automatic logic [7:0] merge_write(input logic [7:0] old, input logic [7:0] wdata,
			input logic lane, input logic [7:0] mask);
		merge_write = lane ? (wdata & mask) : old;
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !state_q.ack;
	assign hit_c0 = (wb_adr_i == `VRDAC_OFF_CONTROL0);
	assign hit_lv = (wb_adr_i == `VRDAC_OFF_LEVEL);

	always_comb begin
		state_d = state_q;
		state_d.ack = req;
		if (req && wb_we_i && hit_c0) begin
			state_d.control0 = merge_write(state_q.control0, wb_dat_i[7:0], wb_sel_i[0],
				`VRDAC_CONTROL0_MASK);
		end
		if (req && wb_we_i && hit_lv) begin
			state_d.level = merge_write(state_q.level, wb_dat_i[7:0], wb_sel_i[0],
				`VRDAC_LEVEL_MASK);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q.control0 <= `VRDAC_CONTROL0_RESET;
			state_q.level <= `VRDAC_LEVEL_RESET;
			state_q.ack <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			if (req && !wb_we_i) begin
				if (hit_c0) begin
					rdata_q <= {24'h000000, state_q.control0 & `VRDAC_CONTROL0_MASK};
				end else if (hit_lv) begin
					rdata_q <= {24'h000000, state_q.level & `VRDAC_LEVEL_MASK};
				end else begin
					rdata_q <= 32'h00000000;
				end
			end
		end
	end

	// Pin input sampler, three stages plus a register updated while stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_in_q1 <= 2'h0;
			pad_in_q2 <= 2'h0;
			pad_in_q3 <= 2'h0;
			pad_in_sync <= 2'h0;
		end else begin
			pad_in_q1 <= pad_in;
			pad_in_q2 <= pad_in_q1;
			pad_in_q3 <= pad_in_q2;
			for (int i = 0; i < 2; i++) begin
				if (pad_in_q2[i] == pad_in_q3[i]) begin
					pad_in_sync[i] <= pad_in_q3[i];
				end
			end
		end
	end

	assign wb_ack_o = state_q.ack;
	assign wb_err_o = 1'b0;
	assign wb_dat_o = rdata_q;

	assign converter_enable = state_q.control0[`VRDAC_BIT_ENABLE];
	assign src = state_q.control0[`VRDAC_BIT_PSS] ? vrdac_pkg::VRDAC_SRC_EXT_PIN
		: vrdac_pkg::VRDAC_SRC_SUPPLY;
	assign ladder_top_ext_pin = (src == vrdac_pkg::VRDAC_SRC_EXT_PIN);
	// Tap k of 32 gives Vneg + (Vpos - Vneg) * k / 32
	assign ladder_tap = converter_enable ? state_q.level[4:0] : 5'h00;
	assign ladder_zero = !converter_enable;
	assign connect = {state_q.control0[`VRDAC_BIT_PIN_TWO], state_q.control0[`VRDAC_BIT_PIN_ONE]};

	vrdac_pin_override u_pin_one (
		.connect(connect[0]),
		.port_out(port_out[0]),
		.port_oe(port_oe[0]),
		.pullup_en(pullup_en[0]),
		.pad_in(pad_in_sync[0]),
		.pad_out(pad_out[0]),
		.pad_oe(pad_oe[0]),
		.pad_pullup(pad_pullup[0]),
		.pad_analog(pad_analog[0]),
		.read_value(pin_read[0])
	);

	vrdac_pin_override u_pin_two (
		.connect(connect[1]),
		.port_out(port_out[1]),
		.port_oe(port_oe[1]),
		.pullup_en(pullup_en[1]),
		.pad_in(pad_in_sync[1]),
		.pad_out(pad_out[1]),
		.pad_oe(pad_oe[1]),
		.pad_pullup(pad_pullup[1]),
		.pad_analog(pad_analog[1]),
		.read_value(pin_read[1])
	);

	a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	a_ack_follows_req: assert property (@(posedge clk) disable iff (!rst_n)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack after request");
	a_level_write: assert property (@(posedge clk) disable iff (!rst_n)
		(req && wb_we_i && hit_lv && wb_sel_i[0]) |=> state_q.level == {3'h0, $past(wb_dat_i[4:0])})
		else $error("level write lost");
	a_level_unimpl: assert property (@(posedge clk) disable iff (!rst_n)
		state_q.level[7:5] == 3'h0) else $error("level upper bits set");
	a_ctrl_unimpl: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q.control0 & ~`VRDAC_CONTROL0_MASK) == 8'h00) else $error("control unimpl bit set");
	a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
		(req && wb_we_i && hit_c0 && wb_sel_i[0]) |=> (converter_enable == $past(wb_dat_i[7])
		&& connect == {$past(wb_dat_i[4]), $past(wb_dat_i[5])}
		&& ladder_top_ext_pin == $past(wb_dat_i[2])))
		else $error("control write lost");
	a_src_select: assert property (@(posedge clk) disable iff (!rst_n)
		ladder_top_ext_pin == state_q.control0[2]) else $error("source select wrong");
	a_tap_disabled: assert property (@(posedge clk) disable iff (!rst_n)
		!converter_enable |-> (ladder_tap == 5'h00 && ladder_zero)) else $error("disabled ladder active");
	a_tap_enabled: assert property (@(posedge clk) disable iff (!rst_n)
		converter_enable |-> ladder_tap == state_q.level[4:0]) else $error("tap mismatch");
	a_pin_override: assert property (@(posedge clk) disable iff (!rst_n)
		connect[0] |-> (pin_read[0] == 1'b0 && pad_oe[0] == 1'b0 && pad_pullup[0] == 1'b0 && pad_analog[0]))
		else $error("pin one not overridden");
	a_pin_two_override: assert property (@(posedge clk) disable iff (!rst_n)
		connect[1] |-> (pin_read[1] == 1'b0 && pad_oe[1] == 1'b0 && pad_pullup[1] == 1'b0 && pad_analog[1]))
		else $error("pin two not overridden");
	a_pin_passthrough: assert property (@(posedge clk) disable iff (!rst_n)
		(connect == 2'h0) |-> (pad_out == port_out && pad_oe == port_oe
		&& pad_pullup == pullup_en && pad_analog == 2'h0))
		else $error("free pin not passed through");
	a_reset_clear: assert property (@(posedge clk)
		$rose(rst_n) |-> (!converter_enable && pad_analog == 2'h0 && state_q.level == 8'h00))
		else $error("reset did not clear");

endmodule

// file: testbench/vrdac_control_tb.sv
`timescale 1ns/1ps
module vrdac_control_tb;
	logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, rd, dat_o;
	logic ack, err, en, ext, zero;
	logic [4:0] tap;
	logic [1:0] pout = 2'h3, poe = 2'h3, pup = 2'h3, pin = 2'h3, pad_out, pad_oe, pad_pu, ana, prd;
	int mismatches = 0, total_checks = 0;
	always #5 clk = ~clk;
	vrdac_control DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.converter_enable(en), .ladder_top_ext_pin(ext), .ladder_tap(tap), .ladder_zero(zero),
		.port_out(pout), .port_oe(poe), .pullup_en(pup), .pad_in(pin), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pullup(pad_pu), .pad_analog(ana), .pin_read(prd));
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle, held until ack is sampled high
	task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			print_verdict;
		end else begin
			rd = dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
			we <= 1'b0;
		end
	endtask
	task rdchk(input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 4'hF, 32'h0);
		chk(rd, exp);
	endtask
	task t_reset;
		rdchk(4'h0, 32'h0);
		rdchk(4'h4, 32'h0);
		chk({en, zero, tap, ana}, {1'b0, 1'b1, 5'h00, 2'h0});
		chk({err, pad_out, pad_oe, pad_pu}, {1'b0, 6'h3F});
		@(posedge clk);
		pin <= 2'h2;
		repeat (6) @(negedge clk);
		chk(prd, 2'h2);
		@(posedge clk);
		pin <= 2'h3;
		repeat (6) @(negedge clk);
	endtask
	task t_ctrl;
		wb(1'b1, 4'h0, 4'h1, 32'hFFFF_FFFF);
		rdchk(4'h0, 32'hB4);
		@(negedge clk);
		chk({en, ext, ana, pad_out, pad_oe, pad_pu}, {1'b1, 1'b1, 2'h3, 6'h00});
		repeat (6) @(negedge clk);
		chk(prd, 2'h0);
		wb(1'b1, 4'h0, 4'h1, 32'h80);
		@(negedge clk);
		chk({en, ext, ana}, {1'b1, 1'b0, 2'h0});
	endtask
	task t_level;
		wb(1'b1, 4'h4, 4'h1, 32'hFF);
		rdchk(4'h4, 32'h1F);
		chk(tap, 5'h1F);
		wb(1'b1, 4'h4, 4'h1, 32'h0A);
		rdchk(4'h4, 32'h0A);
		chk(tap, 5'h0A);
		wb(1'b1, 4'h0, 4'h1, 32'h20);
		repeat (6) @(negedge clk);
		chk({en, zero, tap, ana, pad_out, prd}, {1'b0, 1'b1, 5'h00, 2'h1, 2'h2, 2'h2});
	endtask
	task t_refuse;
		wb(1'b1, 4'h0, 4'h0, 32'hFF);
		rdchk(4'h0, 32'h20);
		wb(1'b1, 4'h8, 4'h1, 32'hFF);
		rdchk(4'h8, 32'h0);
		rdchk(4'h4, 32'h0A);
	endtask
	task t_reset2;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_ctrl;
		t_level;
		t_refuse;
		t_reset2;
		print_verdict;
	end
endmodule
